/* File: hdl/rss_pkg.sv */
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_INIT = 2'b00,
    RSS_RUN = 2'b01
  } rss_state_e;

  typedef logic [7:0] rss_byte_t;

  typedef struct packed {
    logic analog_sat;
    logic digital_sat;
    logic above_high;
    logic below_low;
    logic mux_done;
    logic queue_overrun;
    logic queue_read;
    logic overheat;
    logic trigger_err;
    logic sleep_enter;
    logic flags_clear;
  } rss_evt_s;

  typedef struct packed {
    logic [5:0][15:0] chan;
  } rss_result_s;

endpackage : rss_pkg

/* File: hdl/rss_readout_regs.sv */
// What this block does
// RULE1: Analog saturation event sets bit 3 of the 0xA3 flags.
// RULE2: High-threshold spectral interrupt sets bit 5 of 0xA4.
// RULE3: Low-threshold spectral interrupt sets bit 4 of 0xA4.
// RULE4: Finished sensor mux command sets bit 2 of 0xA6.
// RULE5: Queue overflow sets bit 7 of 0xA7; a queue read clears it.
// RULE6: Overheat sets bit 5 of 0xA7; only writing one clears it.
// RULE7: Wait interval too short for integration sets bit 2 of 0xA7.
// RULE8: Bit 1 of 0xA7 holds while asleep on interrupt; host clear wakes.
// RULE9: Bit 0 of 0xA7 reads one for about 300 us after power-on.
// RULE10: Host leaves the device alone until initialization bit reads zero.
// RULE11: Readout status byte reads identically at 0x60 and 0x94.
// RULE12: Reading readout status latches all 12 result bytes together.
// RULE13: Host reads result bytes right after status for coherent data.
// RULE14: Each channel result is 16 bits, low byte at lower address.
// RULE15: Readout status and result bytes ignore host writes.
// RULE16: Host picks upper alias in start modes, lower in duration mode.
// RULE17: Status bit 7 shows analog or digital saturation of the snapshot.
// RULE18: Status bits 3:0 give the gain used for the snapshot.
// RULE19: Channels 0,1,2 sit at 0x95/96, 0x97/98, 0x99/9A.
// RULE20: All flags but bit 0 of 0xA7, status bit 7 and all result bytes read zero after reset.
// RULE21: 0x60-0x74 reachable only with bank select one, 0x80 up with zero.
// RULE22: Reserved bits read zero and writes to them are ignored.
`include "rss_readout_regs.svh"

module rss_readout_regs
  import rss_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `RSS_INIT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_low_bank_select,
  input rss_evt_s i_evt,
  input wire logic [3:0] i_gain_code,
  input rss_result_s i_result,
  output logic o_status_read,
  output logic o_sleep_active,
  output logic o_init_busy
);

  // Bank routing
  wire logic in_low_win;
  wire logic in_high_win;
  wire logic routed;
  wire logic rd_ok;
  wire logic wr_ok;
  assign in_low_win = (i_addr >= `RSS_LOW_BANK_FIRST) && (i_addr <= `RSS_LOW_BANK_LAST);
  assign in_high_win = (i_addr >= `RSS_HIGH_BANK_FIRST);
  assign routed = (in_low_win & i_low_bank_select) | (in_high_win & ~i_low_bank_select); // [RULE21]
  assign rd_ok = i_rd & routed & i_clk_en;
  assign wr_ok = i_wr & routed & i_clk_en;

  // Address decode
  wire logic status_hit;
  wire logic cond_wr;
  wire logic overheat_w1c;
  wire logic sleep_w1c;
  assign status_hit = rd_ok && ((i_addr == `RSS_ADDR_STATUS_LOW) ||
                                (i_addr == `RSS_ADDR_STATUS_HIGH)); // [RULE11]
  assign cond_wr = wr_ok && (i_addr == `RSS_ADDR_COND_FLAGS); // [RULE15]
  assign overheat_w1c = cond_wr & i_wdata[`RSS_BIT_OVERHEAT]; // [RULE6]
  assign sleep_w1c = cond_wr & i_wdata[`RSS_BIT_SLEEP_ACTIVE]; // [RULE8]
  assign o_status_read = status_hit;

  // Sticky flags; a set in the clearing cycle wins
  logic analog_sat_reg;
  logic above_high_reg;
  logic below_low_reg;
  logic mux_done_reg;
  logic queue_overrun_reg;
  logic overheat_reg;
  logic trigger_err_reg;
  logic sleep_active_reg;
  logic sat_pending_reg;
  logic analog_sat_next;
  logic above_high_next;
  logic below_low_next;
  logic mux_done_next;
  logic queue_overrun_next;
  logic overheat_next;
  logic trigger_err_next;
  logic sleep_active_next;
  logic sat_pending_next;

  assign analog_sat_next = i_evt.analog_sat | (analog_sat_reg & ~i_evt.flags_clear); // [RULE1]
  assign above_high_next = i_evt.above_high | (above_high_reg & ~i_evt.flags_clear); // [RULE2]
  assign below_low_next = i_evt.below_low | (below_low_reg & ~i_evt.flags_clear); // [RULE3]
  assign mux_done_next = i_evt.mux_done | (mux_done_reg & ~i_evt.flags_clear); // [RULE4]
  assign queue_overrun_next = i_evt.queue_overrun |
                              (queue_overrun_reg & ~i_evt.queue_read); // [RULE5]
  assign overheat_next = i_evt.overheat | (overheat_reg & ~overheat_w1c); // [RULE6]
  assign trigger_err_next = i_evt.trigger_err | (trigger_err_reg & ~i_evt.flags_clear); // [RULE7]
  assign sleep_active_next = i_evt.sleep_enter | (sleep_active_reg & ~sleep_w1c); // [RULE8]
  // Saturation since the last status read; the read hands it to the snapshot
  assign sat_pending_next = i_evt.analog_sat | i_evt.digital_sat |
                            (sat_pending_reg & ~status_hit); // [RULE17]

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      analog_sat_reg <= 1'b0; // [RULE20]
      above_high_reg <= 1'b0;
      below_low_reg <= 1'b0;
      mux_done_reg <= 1'b0;
      queue_overrun_reg <= 1'b0;
      overheat_reg <= 1'b0;
      trigger_err_reg <= 1'b0;
      sleep_active_reg <= 1'b0;
      sat_pending_reg <= 1'b0;
    end else if (i_clk_en) begin
      analog_sat_reg <= analog_sat_next;
      above_high_reg <= above_high_next;
      below_low_reg <= below_low_next;
      mux_done_reg <= mux_done_next;
      queue_overrun_reg <= queue_overrun_next;
      overheat_reg <= overheat_next;
      trigger_err_reg <= trigger_err_next;
      sleep_active_reg <= sleep_active_next;
      sat_pending_reg <= sat_pending_next;
    end
  end

  assign o_sleep_active = sleep_active_reg;

  // Initialization timer
  localparam logic [`RSS_INIT_CNT_W-1:0] INIT_LAST = (`RSS_INIT_CNT_W)'(INIT_CYCLES - 1);
  rss_state_e state_reg;
  rss_state_e state_next;
  logic [`RSS_INIT_CNT_W-1:0] init_cnt_reg;
  logic [`RSS_INIT_CNT_W-1:0] init_cnt_next;
  wire logic init_done;
  assign init_done = (init_cnt_reg == INIT_LAST);

  always_comb begin
    state_next = state_reg;
    init_cnt_next = init_cnt_reg;
    case (state_reg)
      RSS_INIT: begin
        if (init_done) begin
          state_next = RSS_RUN; // [RULE9]
        end else begin
          init_cnt_next = init_cnt_reg + 1'b1;
        end
      end
      RSS_RUN: begin
        init_cnt_next = init_cnt_reg;
      end
      default: begin
        state_next = RSS_INIT;
        init_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= RSS_INIT;
      init_cnt_reg <= '0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  wire logic init_busy;
  assign init_busy = (state_reg != RSS_RUN); // [RULE9]
  assign o_init_busy = init_busy;

  // Snapshot taken on a status read at either alias
  wire rss_byte_t status_byte;
  assign status_byte = {sat_pending_reg, 3'b000,
                        i_gain_code[`RSS_GAIN_MSB:`RSS_GAIN_LSB]}; // [RULE17] [RULE18] [RULE22]
  rss_result_s snap_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      snap_reg <= '0; // [RULE20]
    end else if (status_hit) begin
      snap_reg <= i_result; // [RULE12]
    end
  end

  // Result bytes; only software reads reach them, so writes are dropped
  wire rss_byte_t shown_byte [`RSS_SHOWN_BYTES];
  wire logic [`RSS_SHOWN_BYTES-1:0] byte_hit;
  genvar gi;
  generate
    for (gi = 0; gi < `RSS_SHOWN_BYTES; gi++) begin : g_byte
      assign byte_hit[gi] = (i_addr == (`RSS_ADDR_CH0_LOW + 8'(gi))); // [RULE19]
      assign shown_byte[gi] = snap_reg.chan[gi / 2][(gi % 2) * 8 +: 8]; // [RULE14]
    end
  endgenerate

  // Flag bytes with reserved bits at zero
  wire rss_byte_t sat_byte;
  wire rss_byte_t thr_byte;
  wire rss_byte_t sys_byte;
  wire rss_byte_t cond_byte;
  assign sat_byte = 8'(analog_sat_reg) << `RSS_BIT_ANALOG_SAT; // [RULE22]
  assign thr_byte = (8'(above_high_reg) << `RSS_BIT_ABOVE_HIGH) |
                    (8'(below_low_reg) << `RSS_BIT_BELOW_LOW);
  assign sys_byte = 8'(mux_done_reg) << `RSS_BIT_MUX_DONE;
  assign cond_byte = (8'(queue_overrun_reg) << `RSS_BIT_QUEUE_OVERRUN) |
                     (8'(overheat_reg) << `RSS_BIT_OVERHEAT) |
                     (8'(trigger_err_reg) << `RSS_BIT_TRIGGER_ERR) |
                     (8'(sleep_active_reg) << `RSS_BIT_SLEEP_ACTIVE) |
                     (8'(init_busy) << `RSS_BIT_INIT_BUSY);

  // Read mux; unmapped and unrouted addresses read zero
  rss_byte_t rd_value;
  always_comb begin
    rd_value = `RSS_BYTE_RESET;
    for (int k = 0; k < `RSS_SHOWN_BYTES; k++) begin
      if (byte_hit[k]) begin
        rd_value = shown_byte[k];
      end
    end
    case (i_addr)
      `RSS_ADDR_STATUS_LOW, `RSS_ADDR_STATUS_HIGH: rd_value = status_byte; // [RULE11]
      `RSS_ADDR_SAT_FLAGS: rd_value = sat_byte;
      `RSS_ADDR_THR_FLAGS: rd_value = thr_byte;
      `RSS_ADDR_SYS_FLAGS: rd_value = sys_byte;
      `RSS_ADDR_COND_FLAGS: rd_value = cond_byte;
      default: rd_value = rd_value;
    endcase
  end

  // Read data stands for one enabled cycle after the strobe only
  rss_byte_t rdata_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_reg <= `RSS_BYTE_RESET;
    end else if (i_clk_en) begin
      rdata_reg <= rd_ok ? rd_value : `RSS_BYTE_RESET; // [RULE21]
    end
  end
  assign o_rdata = rdata_reg;

endmodule : rss_readout_regs

/* File: hdl/rss_readout_regs.svh */
`ifndef RSS_READOUT_REGS_SVH
`define RSS_READOUT_REGS_SVH

// Register offsets
`define RSS_ADDR_STATUS_LOW 8'h60
`define RSS_ADDR_STATUS_HIGH 8'h94
`define RSS_ADDR_CH0_LOW 8'h95
`define RSS_ADDR_CH0_HIGH 8'h96
`define RSS_ADDR_CH1_LOW 8'h97
`define RSS_ADDR_CH1_HIGH 8'h98
`define RSS_ADDR_CH2_LOW 8'h99
`define RSS_ADDR_CH2_HIGH 8'h9A
`define RSS_ADDR_SAT_FLAGS 8'hA3
`define RSS_ADDR_THR_FLAGS 8'hA4
`define RSS_ADDR_SYS_FLAGS 8'hA6
`define RSS_ADDR_COND_FLAGS 8'hA7

// Bank windows
`define RSS_LOW_BANK_FIRST 8'h60
`define RSS_LOW_BANK_LAST 8'h74
`define RSS_HIGH_BANK_FIRST 8'h80

// Field positions
`define RSS_BIT_ANALOG_SAT 3
`define RSS_BIT_ABOVE_HIGH 5
`define RSS_BIT_BELOW_LOW 4
`define RSS_BIT_MUX_DONE 2
`define RSS_BIT_QUEUE_OVERRUN 7
`define RSS_BIT_OVERHEAT 5
`define RSS_BIT_TRIGGER_ERR 2
`define RSS_BIT_SLEEP_ACTIVE 1
`define RSS_BIT_INIT_BUSY 0
`define RSS_BIT_LATCHED_SAT 7
`define RSS_GAIN_MSB 3
`define RSS_GAIN_LSB 0

// Reset values
`define RSS_BYTE_RESET 8'h00

// Timing
`define RSS_CLK_MHZ 100
`define RSS_INIT_TIME_US 300
`define RSS_INIT_CYCLES (`RSS_INIT_TIME_US * `RSS_CLK_MHZ)
`define RSS_INIT_CNT_W 16

// Result bytes shown at the upper alias
`define RSS_SHOWN_BYTES 6

`endif

/* File: verif/rss_readout_regs_sva.sv */
module rss_readout_regs_sva
  import rss_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_low_bank_select,
  input wire rss_evt_s i_evt,
  input wire logic [3:0] i_gain_code,
  input wire logic o_status_read,
  input wire logic o_sleep_active,
  input wire logic o_init_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  int unsigned cnt_reg;
  wire lo_ok = i_low_bank_select && i_addr >= 8'h60 && i_addr <= 8'h74;
  wire hi_ok = !i_low_bank_select && i_addr >= 8'h80;
  wire hrd = i_clk_en && i_rd && hi_ok;
  wire srd = i_clk_en && i_rd && (lo_ok && i_addr == 8'h60 || hi_ok && i_addr == 8'h94);
  // Saturates so it cannot wrap back into the busy range
  always_ff @(posedge i_core_clk) begin
    if (i_rst) cnt_reg <= 0;
    else if (i_clk_en && cnt_reg < INIT_CYCLES) cnt_reg <= cnt_reg + 1;
  end
  a_status_strobe: assert property (o_status_read == srd)
    else $error("status strobe wrong");
  a_status_gain: assert property ($past(srd) |-> o_rdata[6:0] == {3'h0, $past(i_gain_code)})
    else $error("status gain wrong");
  a_unrouted_zero: assert property ($past(i_clk_en && i_rd && !lo_ok && !hi_ok) |-> !o_rdata)
    else $error("unrouted read not zero");
  a_init_busy: assert property (o_init_busy == (cnt_reg < INIT_CYCLES))
    else $error("init busy length wrong");
  a_sleep_set: assert property (i_clk_en && i_evt.sleep_enter |=> o_sleep_active)
    else $error("sleep not entered");
  a_cond_bits: assert property ($past(hrd && i_addr == 8'hA7) |->
    o_rdata[1:0] == {$past(o_sleep_active), $past(o_init_busy)}) else $error("cond bits wrong");
  a_sat_reserved: assert property ($past(hrd && i_addr == 8'hA3) |-> !o_rdata[2:0])
    else $error("sat reserved set");
  a_thr_reserved: assert property ($past(hrd && i_addr == 8'hA4) |-> !o_rdata[3:0])
    else $error("thr reserved set");
  c_status: cover property (srd);
  c_sleep: cover property (o_sleep_active);
  c_init_done: cover property ($fell(o_init_busy));
endmodule : rss_readout_regs_sva

bind rss_readout_regs rss_readout_regs_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_low_bank_select(i_low_bank_select),
  .i_evt(i_evt), .i_gain_code(i_gain_code), .o_status_read(o_status_read),
  .o_sleep_active(o_sleep_active), .o_init_busy(o_init_busy));

/* File: verif/testbench.sv */
module testbench
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned INIT = 40;
  localparam logic [7:0] ZA[6] = '{8'hA3, 8'hA4, 8'hA6, 8'h94, 8'h95, 8'h9A};
  localparam logic [10:0] FE[6] = '{11'h400, 11'h100, 11'h080, 11'h040, 11'h020, 11'h004};
  localparam logic [10:0] FC[6] = '{11'h001, 11'h001, 11'h001, 11'h001, 11'h010, 11'h001};
  localparam logic [7:0] FA[6] = '{8'hA3, 8'hA4, 8'hA4, 8'hA6, 8'hA7, 8'hA7};
  localparam logic [7:0] FX[6] = '{8'h08, 8'h20, 8'h10, 8'h04, 8'h80, 8'h04};
  localparam logic [15:0] RV[3] = '{16'h1234, 16'h5678, 16'h9ABC};
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_clk_en = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_low_bank_select = 1'b0, o_status_read, o_sleep_active, o_init_busy;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [3:0] i_gain_code = 4'h0;
  rss_evt_s i_evt = '0;
  rss_result_s i_result = '0;
  int n_fail = 0, checks = 0, cyc = 0;
  always #5 i_core_clk = ~i_core_clk;
  rss_readout_regs #(.INIT_CYCLES(INIT)) u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_low_bank_select(i_low_bank_select), .i_evt(i_evt),
    .i_gain_code(i_gain_code), .i_result(i_result), .o_status_read(o_status_read),
    .o_sleep_active(o_sleep_active), .o_init_busy(o_init_busy));
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    check($sformatf("addr %h", a), o_rdata, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic ev(input rss_evt_s e);
    @(posedge i_core_clk);
    i_evt <= e;
    @(posedge i_core_clk);
    i_evt <= '0;
  endtask : ev
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // Polling the busy bit is the one access allowed during init
    rd(8'hA7, 8'h01);
    for (int w = 0; w < 100 && o_init_busy !== 1'b0; w++) @(posedge i_core_clk);
    rd(8'hA7, 8'h00);
    foreach (ZA[i]) rd(ZA[i], 8'h00);
    $display("test reset done");
    foreach (FE[i]) begin
      ev(FE[i]);
      rd(FA[i], FX[i]);
      ev(FC[i]);
      rd(FA[i], 8'h00);
    end
    ev(11'h008);
    ev(11'h001);
    rd(8'hA7, 8'h20);
    wr(8'hA7, 8'hDF);
    rd(8'hA7, 8'h20);
    wr(8'hA7, 8'h20);
    rd(8'hA7, 8'h00);
    // Frozen clock enable must drop the event
    @(posedge i_core_clk) i_clk_en <= 1'b0;
    ev(11'h008);
    @(posedge i_core_clk) i_clk_en <= 1'b1;
    rd(8'hA7, 8'h00);
    $display("test flags done");
    ev(11'h002);
    #1;
    check("sleep", {7'h00, o_sleep_active}, 8'h01);
    rd(8'hA7, 8'h02);
    wr(8'hA7, 8'h02);
    rd(8'hA7, 8'h00);
    $display("test sleep done");
    @(posedge i_core_clk);
    foreach (RV[k]) i_result.chan[k] <= RV[k];
    i_gain_code <= 4'hA;
    ev(11'h200);
    rd(8'h94, 8'h8A);
    // New live values, so a missing snapshot shows
    @(posedge i_core_clk);
    foreach (RV[k]) i_result.chan[k] <= ~RV[k];
    foreach (RV[k]) begin
      rd(8'h95 + 8'(2 * k), RV[k][7:0]);
      rd(8'h96 + 8'(2 * k), RV[k][15:8]);
    end
    wr(8'h95, 8'hFF);
    rd(8'h95, 8'h34);
    @(posedge i_core_clk) i_low_bank_select <= 1'b1;
    rd(8'h60, 8'h0A);
    rd(8'h95, 8'h00);
    @(posedge i_core_clk) i_low_bank_select <= 1'b0;
    rd(8'h60, 8'h00);
    rd(8'h95, 8'hCB);
    $display("test snapshot done");
    stop_test();
  end
endmodule : testbench
